/* File: core/emsc_defines.vh */
// constants for the external memory strobe control block
`ifndef EMSC_DEFINES_VH
`define EMSC_DEFINES_VH
// oscillator clocks per machine cycle and per address-latch period
`define EMSC_OSC_PER_MCYCLE 12
`define EMSC_OSC_PER_ALE 6
// slot of the address-latch pulse and of the fetch strobe within a half cycle
`define EMSC_ALE_LAST_SLOT 3'h1
`define EMSC_PROGRAM_FETCH_STROBE_FIRST_SLOT 3'h3
`define EMSC_LAST_SLOT 3'h5
// read data is sampled in this slot of the second data cycle
`define EMSC_RDATA_SLOT 3'h5
// machine cycles the reset pin must stay high
`define EMSC_RST_MCYCLES 2
// size of internal program memory, code below it is internal when select is high
`define EMSC_INT_ROM_SIZE 17'h01000
// port 3 bit positions of the alternate roles
`define EMSC_P3_RXD 0
`define EMSC_P3_TXD 1
`define EMSC_P3_IRQ0 2
`define EMSC_P3_IRQ1 3
`define EMSC_P3_TMR0 4
`define EMSC_P3_TMR1 5
`define EMSC_P3_WR 6
`define EMSC_P3_RD 7
`endif

/* File: core/emsc_reset_qualifier.v */
// reset pin qualifier: counts consecutive high samples
`timescale 1ns/1ns
module emsc_reset_qualifier #(
    parameter CNT_W = 5,
    parameter HOLD = 24
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire reset_pin_in,
    output reg qualified_out
);
    // ============================================================
    // consecutive high sample counter
    reg [CNT_W-1:0] count_reg;
    // last count value, cut to the counter width on purpose
    localparam integer HOLD_LAST_INT = HOLD - 1;
    localparam [CNT_W-1:0] HOLD_LAST = HOLD_LAST_INT[CNT_W-1:0];

    // a low sample restarts the count, short pulses never qualify
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            count_reg <= {CNT_W{1'b0}};
            qualified_out <= 1'b0;
        end else if (!reset_pin_in) begin
            count_reg <= {CNT_W{1'b0}}; // [R18]
            qualified_out <= 1'b0;
        end else begin
            if (count_reg != HOLD_LAST)
                count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // [R18]
            else
                qualified_out <= 1'b1; // [R1]
        end
    end
endmodule // emsc_reset_qualifier

/* File: core/emsc_strobe_ctrl.v */
// external memory strobe control: latch pulse, fetch strobe, data strobes, port 3 roles
//
// Overview of operation
// R1: reset needs two machine cycles high
// R2: latch pulse at one sixth oscillator
// R3: latch pulse marks low address byte
// R4: one latch pulse skipped per data access
// R5: disable bit stops free running latch
// R6: disabled latch pulses only during data moves
// R7: fetch strobe reads external program memory
// R8: fetch strobe twice per machine cycle
// R9: two fetch strobes skipped per data access
// R10: no fetch strobe for internal fetches
// R11: select held low forces external fetch
// R12: write strobe on port 3 bit 6
// R13: read strobe on port 3 bit 7
// R14: interrupt inputs on port 3 bits 2,3
// R15: timer count inputs on port 3 bits 4,5
// R16: serial receive from port 3 bit 0
// R17: serial transmit on port 3 bit 1
// R18: reset pin counted on oscillator clock
// R19: strobes active low, idle high
`timescale 1ns/1ns
`include "emsc_defines.vh"
module emsc_strobe_ctrl #(
    parameter INT_ROM_SIZE = `EMSC_INT_ROM_SIZE,
    parameter RST_HOLD = `EMSC_RST_MCYCLES * `EMSC_OSC_PER_MCYCLE
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire reset_pin_in,
    input wire external_access_select_in,
    input wire ale_disable_in,
    input wire [15:0] pc_in,
    input wire data_req_in,
    input wire data_write_in,
    input wire [15:0] data_addr_in,
    input wire [7:0] data_wdata_in,
    input wire [7:0] p0_in,
    input wire [7:0] p3_in,
    input wire [7:0] p3_latch_in,
    input wire [7:0] p3_alt_en_in,
    input wire serial_tx_in,
    output reg core_reset_out,
    output reg ale_out,
    output reg program_fetch_strobe_n_out,
    output reg [7:0] p0_out,
    output reg [7:0] p0_oe_n_out,
    output reg [7:0] p2_out,
    output reg [7:0] p3_out,
    output reg [7:0] p3_oe_n_out,
    output reg data_busy_out,
    output reg data_done_out,
    output reg [7:0] data_rdata_out,
    output reg serial_rx_out,
    output reg external_irq_zero_n_out,
    output reg external_irq_one_n_out,
    output reg timer_zero_count_input_out,
    output reg timer_one_count_input_out
);
    // ============================================================
    // machine cycle states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DCYC1 = 2'h1;
    localparam [1:0] ST_DCYC2 = 2'h2;
    localparam [16:0] ROM_SIZE = INT_ROM_SIZE;

    reg [2:0] slot_reg;
    reg half_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg pend_reg;
    reg wr_reg;
    reg [15:0] addr_reg;
    reg [7:0] wdata_reg;
    wire qual_rst;

    // ============================================================
    // reset pin qualification
    emsc_reset_qualifier #(
        .CNT_W(6),
        .HOLD(RST_HOLD)
    ) u_rst_qual (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .reset_pin_in(reset_pin_in),
        .qualified_out(qual_rst)
    );

    // ============================================================
    // timing decode
    wire last_slot = (slot_reg == `EMSC_LAST_SLOT);
    wire mc_end = half_reg && last_slot;
    wire busy = pend_reg || (state_reg != ST_IDLE);
    wire accept = data_req_in && !busy && !qual_rst;
    wire ale_slot = (slot_reg <= `EMSC_ALE_LAST_SLOT);
    wire ale_skip = (state_reg == ST_DCYC2) && !half_reg; // [R4]
    wire ale_en = !ale_disable_in || (state_reg != ST_IDLE); // [R5] [R6]
    wire ale_next = ale_slot && !ale_skip && ale_en && !qual_rst; // [R2] [R3]
    // low select always fetches externally, high only above internal memory
    wire fetch_ext = !external_access_select_in || ({1'b0, pc_in} >= ROM_SIZE); // [R10] [R11]
    wire program_fetch_strobe_act = (slot_reg >= `EMSC_PROGRAM_FETCH_STROBE_FIRST_SLOT) && fetch_ext // [R8]
        && (state_reg != ST_DCYC2) && !qual_rst; // [R9]
    wire dstrobe = !qual_rst && (((state_reg == ST_DCYC1) && half_reg && (slot_reg >= `EMSC_PROGRAM_FETCH_STROBE_FIRST_SLOT))
        || ((state_reg == ST_DCYC2) && !half_reg));
    wire wdrive = !qual_rst && wr_reg && (((state_reg == ST_DCYC1) && half_reg && !ale_slot)
        || ((state_reg == ST_DCYC2) && !half_reg));
    wire data_ale = (state_reg == ST_DCYC1) && half_reg;

    // ============================================================
    // phase counter: six slots per half, two halves per machine cycle
    always @(posedge core_clk_in) begin
        if (!rst_n_in || qual_rst) begin
            slot_reg <= 3'h0;
            half_reg <= 1'b0;
        end else if (last_slot) begin
            slot_reg <= 3'h0; // [R2]
            half_reg <= ~half_reg;
        end else begin
            slot_reg <= slot_reg + 3'h1;
        end
    end

    // ============================================================
    // data access sequencer
    always @* begin
        state_next = state_reg;
        if (mc_end) begin
            case (state_reg)
                ST_IDLE: begin
                    if (pend_reg)
                        state_next = ST_DCYC1;
                end
                ST_DCYC1: begin
                    state_next = ST_DCYC2;
                end
                ST_DCYC2: begin
                    state_next = pend_reg ? ST_DCYC1 : ST_IDLE;
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // request capture and state update
    always @(posedge core_clk_in) begin
        if (!rst_n_in || qual_rst) begin
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                pend_reg <= 1'b1;
                wr_reg <= data_write_in;
                addr_reg <= data_addr_in;
                wdata_reg <= data_wdata_in;
            end else if (mc_end && (state_next == ST_DCYC1)) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // ============================================================
    // memory bus outputs, all registered
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            core_reset_out <= 1'b0;
            ale_out <= 1'b0;
            program_fetch_strobe_n_out <= 1'b1;
            p0_out <= 8'h00;
            p0_oe_n_out <= 8'hFF;
            p2_out <= 8'h00;
            data_busy_out <= 1'b0;
            data_done_out <= 1'b0;
            data_rdata_out <= 8'h00;
        end else begin
            core_reset_out <= qual_rst; // [R1]
            ale_out <= ale_next; // [R2] [R3]
            program_fetch_strobe_n_out <= ~program_fetch_strobe_act; // [R7] [R19]
            // low address during the latch pulse, write data in the strobe window
            if (ale_next) begin
                p0_out <= data_ale ? addr_reg[7:0] : pc_in[7:0]; // [R3]
                p0_oe_n_out <= 8'h00;
            end else if (wdrive) begin
                p0_out <= wdata_reg;
                p0_oe_n_out <= 8'h00;
            end else begin
                p0_oe_n_out <= 8'hFF;
            end
            p2_out <= (state_reg != ST_IDLE) ? addr_reg[15:8] : pc_in[15:8];
            data_busy_out <= busy || accept;
            data_done_out <= 1'b0;
            if ((state_reg == ST_DCYC2) && !half_reg && (slot_reg == `EMSC_RDATA_SLOT)) begin
                data_done_out <= 1'b1;
                if (!wr_reg)
                    data_rdata_out <= p0_in;
            end
        end
    end

    // ============================================================
    // port 3 alternate roles
    reg [7:0] p3_next;
    reg [7:0] p3_oe_n_next;
    always @* begin
        p3_next = p3_latch_in;
        p3_oe_n_next = p3_latch_in; // quasi-bidirectional: drive low bits only
        if (p3_alt_en_in[`EMSC_P3_TXD]) begin
            p3_next[`EMSC_P3_TXD] = serial_tx_in; // [R17]
            p3_oe_n_next[`EMSC_P3_TXD] = 1'b0;
        end
        if (p3_alt_en_in[`EMSC_P3_WR]) begin
            p3_next[`EMSC_P3_WR] = ~(dstrobe && wr_reg); // [R12] [R19]
            p3_oe_n_next[`EMSC_P3_WR] = 1'b0;
        end
        if (p3_alt_en_in[`EMSC_P3_RD]) begin
            p3_next[`EMSC_P3_RD] = ~(dstrobe && !wr_reg); // [R13] [R19]
            p3_oe_n_next[`EMSC_P3_RD] = 1'b0;
        end
        // input roles release the pin so the outside can drive it
        if (p3_alt_en_in[`EMSC_P3_RXD])
            p3_oe_n_next[`EMSC_P3_RXD] = 1'b1;
        if (p3_alt_en_in[`EMSC_P3_IRQ0])
            p3_oe_n_next[`EMSC_P3_IRQ0] = 1'b1;
        if (p3_alt_en_in[`EMSC_P3_IRQ1])
            p3_oe_n_next[`EMSC_P3_IRQ1] = 1'b1;
        if (p3_alt_en_in[`EMSC_P3_TMR0])
            p3_oe_n_next[`EMSC_P3_TMR0] = 1'b1;
        if (p3_alt_en_in[`EMSC_P3_TMR1])
            p3_oe_n_next[`EMSC_P3_TMR1] = 1'b1;
    end

    // port 3 pins and alternate inputs, registered
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            p3_out <= 8'hFF;
            p3_oe_n_out <= 8'hFF;
            serial_rx_out <= 1'b1;
            external_irq_zero_n_out <= 1'b1;
            external_irq_one_n_out <= 1'b1;
            timer_zero_count_input_out <= 1'b1;
            timer_one_count_input_out <= 1'b1;
        end else begin
            p3_out <= p3_next;
            p3_oe_n_out <= p3_oe_n_next;
            // a disabled role reads idle high
            serial_rx_out <= p3_in[`EMSC_P3_RXD] | ~p3_alt_en_in[`EMSC_P3_RXD]; // [R16]
            external_irq_zero_n_out <= p3_in[`EMSC_P3_IRQ0] | ~p3_alt_en_in[`EMSC_P3_IRQ0]; // [R14]
            external_irq_one_n_out <= p3_in[`EMSC_P3_IRQ1] | ~p3_alt_en_in[`EMSC_P3_IRQ1]; // [R14]
            timer_zero_count_input_out <= p3_in[`EMSC_P3_TMR0] | ~p3_alt_en_in[`EMSC_P3_TMR0]; // [R15]
            timer_one_count_input_out <= p3_in[`EMSC_P3_TMR1] | ~p3_alt_en_in[`EMSC_P3_TMR1]; // [R15]
        end
    end
endmodule // emsc_strobe_ctrl

/* File: sim/emsc_strobe_ctrl_assertions.sv */
// assertion checker for the strobe control block
`timescale 1ns/1ns
module emsc_strobe_checker #(parameter RST_HOLD = 24) (
    input wire core_clk_in, rst_n_in, reset_pin_in, external_access_select_in, ale_disable_in,
    input wire [15:0] pc_in,
    input wire [7:0] p3_in, p3_alt_en_in, p3_out,
    input wire serial_tx_in, core_reset_out, ale_out, program_fetch_strobe_n_out, data_busy_out,
    input wire serial_rx_out, external_irq_zero_n_out, external_irq_one_n_out,
    input wire timer_zero_count_input_out, timer_one_count_input_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========
    // strobe shapes
    property p_ale_width; $rose(ale_out) |=> ale_out ##1 !ale_out; endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch pulse width");
    property p_fetch_width;
        $fell(program_fetch_strobe_n_out) |=> !program_fetch_strobe_n_out [*2] ##1 program_fetch_strobe_n_out;
    endproperty
    a_fetch_width: assert property (p_fetch_width) else $error("fetch strobe width");
    property p_fetch_internal; (external_access_select_in && pc_in < 16'h1000) [*5] |-> program_fetch_strobe_n_out;
    endproperty
    a_fetch_internal: assert property (p_fetch_internal) else $error("fetch strobe on internal code");
    property p_ale_off; (ale_disable_in && !data_busy_out) [*3] |-> !ale_out; endproperty
    a_ale_off: assert property (p_ale_off) else $error("latch pulse while disabled");
    property p_wr_strobe;
        p3_alt_en_in[6] && $fell(p3_out[6]) |-> data_busy_out ##1 !p3_out[6] [*8] ##1 p3_out[6];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe shape");
    property p_rd_strobe;
        p3_alt_en_in[7] && $fell(p3_out[7]) |-> data_busy_out ##1 !p3_out[7] [*8] ##1 p3_out[7];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe shape");
    // ==========
    // reset pin and port 3 roles
    property p_reset_qual; $rose(core_reset_out) |-> $past(reset_pin_in, 2) && $past(reset_pin_in, RST_HOLD + 1);
    endproperty
    a_reset_qual: assert property (p_reset_qual) else $error("reset taken too early");
    property p_reset_quiet; core_reset_out [*3] |-> program_fetch_strobe_n_out && !ale_out; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("strobes active in reset");
    property p_alt_in; $past(rst_n_in) |-> {timer_one_count_input_out, timer_zero_count_input_out,
        external_irq_one_n_out, external_irq_zero_n_out, serial_rx_out} == ({$past(p3_in[5:2]), $past(p3_in[0])}
        | ~{$past(p3_alt_en_in[5:2]), $past(p3_alt_en_in[0])});
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("port 3 input role");
    property p_tx; $past(rst_n_in) && $past(p3_alt_en_in[1]) && !$past(core_reset_out)
        |-> p3_out[1] == $past(serial_tx_in);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pin role");
    c_write: cover property ($fell(p3_out[6]));
    c_read: cover property ($fell(p3_out[7]));
    c_reset: cover property ($rose(core_reset_out));
endmodule // emsc_strobe_checker

bind emsc_strobe_ctrl emsc_strobe_checker #(.RST_HOLD(RST_HOLD)) u_emsc_strobe_checker (
    .core_clk_in, .rst_n_in, .reset_pin_in, .external_access_select_in, .ale_disable_in, .pc_in,
    .p3_in, .p3_alt_en_in, .p3_out, .serial_tx_in, .core_reset_out, .ale_out, .program_fetch_strobe_n_out,
    .data_busy_out, .serial_rx_out, .external_irq_zero_n_out, .external_irq_one_n_out,
    .timer_zero_count_input_out, .timer_one_count_input_out);

/* File: sim/emsc_ext_mem_model.sv */
// external memory with address latch on the far side of the bus
`timescale 1ns/1ns
module emsc_ext_mem_model (
    input wire core_clk_in,
    input wire ale_in,
    input wire fetch_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [7:0] p0_out_in,
    output logic [7:0] p0_drv_out
);
    logic [7:0] mem [0:255];
    logic [7:0] lat_addr = 8'h00;
    initial p0_drv_out = 8'h00;
    // latch low address, store writes, answer reads, toggle when released
    always @(posedge core_clk_in) begin
        if (ale_in) lat_addr <= p0_out_in;
        if (!wr_n_in) mem[lat_addr] <= p0_out_in;
        if (!rd_n_in) p0_drv_out <= mem[lat_addr];
        else if (!fetch_n_in) p0_drv_out <= ~lat_addr;
        else p0_drv_out <= ~p0_drv_out;
    end
endmodule // emsc_ext_mem_model

/* File: sim/tb_external_memory_strobe_control.sv */
// self-checking testbench for the external memory strobe control block
`timescale 1ns/1ns
module tb_external_memory_strobe_control;
    logic core_clk_in = 0, rst_n_in = 0, rpin = 0, sel = 0, dis = 0, req = 0, wr = 0, tx = 1;
    logic [15:0] pc = 16'h0000, daddr = 16'h0000;
    logic [7:0] wdata = 8'h00, drv = 8'hFF, alt = 8'hFF;
    logic [3:0] prv = 4'h0;
    wire [7:0] p0_in, p0_out, p3_out, rdata;
    wire crst, ale, fetch_n, busy, done, rx, i0_n, i1_n, t0, t1;
    wire [7:0] p2, p0oe, p3oe;
    wire [7:0] p3_in = drv & p3_out;
    int fail_count = 0, total_checks = 0, cyc = 0, n_ale = 0, n_fet = 0, n_wr = 0, n_done = 0;
    emsc_strobe_ctrl #(.RST_HOLD(4)) u_emsc_strobe_ctrl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .reset_pin_in(rpin), .external_access_select_in(sel), .ale_disable_in(dis), .pc_in(pc),
        .data_req_in(req), .data_write_in(wr), .data_addr_in(daddr), .data_wdata_in(wdata), .p0_in(p0_in),
        .p3_in(p3_in), .p3_latch_in(8'hFF), .p3_alt_en_in(alt), .serial_tx_in(tx), .core_reset_out(crst),
        .ale_out(ale), .program_fetch_strobe_n_out(fetch_n), .p0_out(p0_out), .p0_oe_n_out(p0oe), .p2_out(p2),
        .p3_out(p3_out), .p3_oe_n_out(p3oe), .data_busy_out(busy), .data_done_out(done), .data_rdata_out(rdata),
        .serial_rx_out(rx), .external_irq_zero_n_out(i0_n), .external_irq_one_n_out(i1_n),
        .timer_zero_count_input_out(t0), .timer_one_count_input_out(t1));
    emsc_ext_mem_model u_emsc_ext_mem_model (.core_clk_in(core_clk_in), .ale_in(ale), .fetch_n_in(fetch_n),
        .rd_n_in(p3_out[7]), .wr_n_in(p3_out[6]), .p0_out_in(p0_out), .p0_drv_out(p0_in));
    always #4 core_clk_in = ~core_clk_in;
    // ==========
    // edge counters and hang guard
    always @(posedge core_clk_in) begin
        prv <= {ale, fetch_n, p3_out[6], done};
        n_ale += ale && !prv[3];
        n_fet += !fetch_n && prv[2];
        n_wr += !p3_out[6] && prv[1];
        n_done += done && !prv[0];
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            summarize();
        end
    end
    // ==========
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic span(input int ea, input int ef, input int ew, input int ed);
        int s0, s1, s2, s3;
        s0 = n_ale;
        s1 = n_fet;
        s2 = n_wr;
        s3 = n_done;
        repeat (48) @(posedge core_clk_in);
        #1;
        chk(n_ale - s0, ea);
        chk(n_fet - s1, ef);
        chk(n_wr - s2, ew);
        chk(n_done - s3, ed);
    endtask
    task automatic setf(input logic s, input logic [15:0] p);
        for (int i = 0; i < 14 && ale !== 1'b1; i++) begin
            @(posedge core_clk_in);
            #1;
        end
        @(posedge core_clk_in);
        sel <= s;
        pc <= p;
        #1;
    endtask
    // ==========
    // scenarios
    task automatic t_fetch;
        setf(1'b0, 16'h0100);
        span(8, 8, 0, 0);
        setf(1'b1, 16'h0100);
        span(8, 0, 0, 0);
        setf(1'b1, 16'h2000);
        span(8, 8, 0, 0);
        $display("fetch test done");
    endtask
    task automatic t_access(input logic w, input logic [15:0] a, input logic [7:0] d, input logic ds, input int ea);
        setf(1'b0, 16'h0000);
        @(posedge core_clk_in);
        dis <= ds;
        req <= 1'b1;
        wr <= w;
        daddr <= a;
        wdata <= d;
        #1;
        fork
            span(ea, 6, w, 1);
            begin
                repeat (2) @(posedge core_clk_in);
                req <= 1'b0;
            end
            // high address and data bus drive at the end of the access
            begin
                @(posedge done);
                #1;
                chk(p2, a[15:8]);
                chk(p0oe, w ? 8'h00 : 8'hFF);
            end
        join
        if (!w) chk(rdata, d);
        $display("data access test done");
    endtask
    task automatic t_alt;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk_in);
            alt <= i ? 8'hFF : 8'h00;
            drv <= 8'hC2;
            tx <= 1'b0;
            repeat (3) @(posedge core_clk_in);
            #1;
            chk({t1, t0, i1_n, i0_n, rx}, i ? 5'h00 : 5'h1F);
            chk(p3_out[1], i ? 1'b0 : 1'b1);
            chk(p3oe, i ? 8'h3D : 8'hFF);
        end
        @(posedge core_clk_in);
        drv <= 8'hFF;
        tx <= 1'b1;
        $display("port 3 role test done");
    endtask
    task automatic t_reset;
        // re-enable free latch pulses just after a fetch strobe falls, so no pulse is cut
        for (int i = 0; i < 14 && !(fetch_n === 1'b0 && prv[2] === 1'b1); i++) begin
            @(posedge core_clk_in);
            #1;
        end
        @(posedge core_clk_in);
        dis <= 1'b0;
        setf(1'b1, 16'h0100);
        @(posedge core_clk_in);
        rpin <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rpin <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rpin <= 1'b1;
        #1;
        chk(crst, 1'b0);
        repeat (8) @(posedge core_clk_in);
        #1;
        chk(crst, 1'b1);
        span(0, 0, 0, 0);
        $display("reset pin test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        t_fetch();
        t_access(1'b1, 16'h1234, 8'h5A, 1'b0, 7);
        t_access(1'b0, 16'h1234, 8'h5A, 1'b1, 3);
        t_alt();
        t_reset();
        summarize();
    end
endmodule // tb_external_memory_strobe_control
